// ---- logic/e1fe_ctrl.sv ----
// e1fe_ctrl: line front-end control of a single-channel E1 interface.
// assumes all pins synchronous to ref_clk_i and an 8-bit register port
// driven by the host interface logic outside this block.
//
// Overview of operation
// [R1] 75 ohm template: lead 0001100, body 0110000
// [R2] 120 ohm template: lead 0001111, body 0111100
// [R3] scale resets to 100001, 3% per step
// [R4] transmit termination: internal 75/120, or external
// [R5] hardware mode: impedance pin picks matching
// [R6] float bit floats transmit outputs, path runs
// [R7] hardware mode: float pin floats transmit outputs
// [R8] float on clock loss, power-down, reset
// [R9] transmit clock lost after 70 idle cycles
// [R10] power-down bit stops transmit, floats outputs
// [R11] hardware mode: both pattern pins power down
// [R12] receive termination uses transmit scheme
// [R13] monitor gain selects 0/22/26/32 dB
// [R14] gain codes 00,01,10,11 in order
// [R15] hardware mode: monitor pin gives 0/26 dB
// [R16] nonzero monitor gain suppresses loss-of-signal
// [R17] equalizer bit enables equalizer, programmable level
// [R18] hardware mode: equalizer off, fixed sensitivity
// [R19] slicer threshold 40/50/60/70 percent
// [R20] recovery bypass routes slicer to rails
// [R21] recovered clock tracks sliced data jitter
// [R22] bypass only in dual-rail receive mode
// [R23] mode 11 bypasses; clock is rail XOR
// [R24] receive mode picks AMI or HDB3
// [R25] single rail: bit0 0 HDB3, 1 AMI
// [R26] hardware mode: path pins set both modes
// [R27] samples 7-bit sign-magnitude, 4x16 entries
// [R28] shape select 11xx uses user waveform
`timescale 1ns/1ps
module e1fe_ctrl #(
  parameter int LOSS_CYC = e1fe_pkg::TXCLK_LOSS_CYC,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sw_reset_i,
  // register port
  input wire e1fe_pkg::e1fe_regreq_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  // hardware control straps
  input wire logic hw_mode_i,
  input wire logic impedance_sel_pin_i,
  input wire logic [3:0] shape_template_sel_pin_i,
  input wire logic tx_float_pin_i,
  input wire logic pattern_pin_hi_i,
  input wire logic pattern_pin_lo_i,
  input wire logic monitor_boost_pin_i,
  input wire logic path_mode_pin_hi_i,
  input wire logic path_mode_pin_lo_i,
  // transmit side
  input wire logic tx_clock_i,
  input wire logic mclk_lost_i,
  input wire logic remote_loopback_i,
  input wire logic internal_pattern_i,
  input wire logic tx_clk_irq_mask_i,
  input wire logic tx_pulse_pos_i,
  input wire logic tx_pulse_neg_i,
  output logic tx_line_pos_o,
  output logic tx_line_neg_o,
  output logic tx_line_oe_o,
  output logic tx_powerdown_o,
  output logic tx_clock_lost_o,
  output logic tx_clk_irq_o,
  // waveform template
  input wire logic tmpl_wr_i,
  input wire logic [5:0] tmpl_waddr_i,
  input wire logic [6:0] template_sample_value_i,
  input wire logic [5:0] tmpl_raddr_i,
  output logic [6:0] tmpl_sample_o,
  output logic [5:0] amplitude_scale_o,
  // termination and analog settings
  output logic tx_term_internal_o,
  output logic tx_term_120_o,
  output logic rx_term_internal_o,
  output logic rx_term_120_o,
  output logic [1:0] monitor_boost_sel_o,
  output logic los_enable_o,
  output logic equalizer_enable_o,
  output logic [4:0] los_level_o,
  output logic [1:0] decision_threshold_sel_o,
  output logic [1:0] tx_mode_o,
  output logic [1:0] rx_rail_codec_mode_o,
  output logic rx_hdb3_o,
  // receive stream: slicer and recovery in, rails out
  input wire logic rx_in_valid_i,
  output logic rx_in_ready_o,
  input wire logic rx_line_pos_i,
  input wire logic rx_line_neg_i,
  input wire logic cdr_pos_i,
  input wire logic cdr_neg_i,
  input wire logic cdr_clk_i,
  output logic rx_out_valid_o,
  input wire logic rx_out_ready_i,
  output logic rx_rail_pos_o,
  output logic rx_rail_neg_o,
  output logic rx_clock_o
);
  import e1fe_pkg::*;

  // ===========================================================
  // helpers
  function automatic logic [6:0] rom_sample(input logic sel120,
                                            input logic [5:0] idx);
    logic [6:0] s;
    s = SAMPLE_ZERO;
    if (idx == LEAD_IDX) begin
      s = sel120 ? T120_LEAD : T75_LEAD; // [R1] [R2]
    end else if (idx >= BODY_FIRST && idx <= BODY_LAST) begin
      s = sel120 ? T120_BODY : T75_BODY; // [R1] [R2]
    end
    return s;
  endfunction

  function automatic logic is_wr(input e1fe_regreq_s r,
                                 input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // ===========================================================
  // register file
  logic [7:0] term_ff, txc0_ff, txc1_ff, txc2_ff;
  logic [7:0] rxc0_ff, rxc1_ff, rxc2_ff;

  // one process per register group, all written by the port
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_ff <= RST_ZERO;
      txc0_ff <= RST_ZERO;
      txc1_ff <= RST_ZERO;
      txc2_ff <= RST_SCALE; // [R3]
    end else if (sw_reset_i) begin
      term_ff <= RST_ZERO;
      txc0_ff <= RST_ZERO;
      txc1_ff <= RST_ZERO;
      txc2_ff <= RST_SCALE; // [R3]
    end else begin
      if (is_wr(reg_req_i, ADDR_TERM)) term_ff <= reg_req_i.wdata;
      if (is_wr(reg_req_i, ADDR_TXC0)) txc0_ff <= reg_req_i.wdata;
      if (is_wr(reg_req_i, ADDR_TXC1)) txc1_ff <= reg_req_i.wdata;
      if (is_wr(reg_req_i, ADDR_TXC2)) txc2_ff <= reg_req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxc0_ff <= RST_ZERO;
      rxc1_ff <= RST_ZERO;
      rxc2_ff <= RST_ZERO;
    end else if (sw_reset_i) begin
      rxc0_ff <= RST_ZERO;
      rxc1_ff <= RST_ZERO;
      rxc2_ff <= RST_ZERO;
    end else begin
      if (is_wr(reg_req_i, ADDR_RXC0)) rxc0_ff <= reg_req_i.wdata;
      if (is_wr(reg_req_i, ADDR_RXC1)) rxc1_ff <= reg_req_i.wdata;
      if (is_wr(reg_req_i, ADDR_RXC2)) rxc2_ff <= reg_req_i.wdata;
    end
  end

  // read data one cycle after the strobe; unmapped offsets read zero
  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = RST_ZERO;
    unique case (reg_req_i.addr)
      ADDR_TERM: nxt_rdata = term_ff;
      ADDR_TXC0: nxt_rdata = txc0_ff;
      ADDR_TXC1: nxt_rdata = txc1_ff;
      ADDR_TXC2: nxt_rdata = txc2_ff;
      ADDR_RXC0: nxt_rdata = rxc0_ff;
      ADDR_RXC1: nxt_rdata = rxc1_ff;
      ADDR_RXC2: nxt_rdata = rxc2_ff;
      default: nxt_rdata = RST_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= RST_ZERO;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // ===========================================================
  // effective settings: register or strap
  logic [3:0] shape_eff;
  logic tx_int_eff, tx_120_eff, rx_int_eff, rx_120_eff;
  logic [1:0] mon_eff, tx_mode_eff, rx_mode_eff;
  logic eq_eff, pd_eff, float_req;

  assign shape_eff = hw_mode_i ? shape_template_sel_pin_i
                               : txc1_ff[SHAPE_LSB +: 4];
  // internal matching when the top term bit is clear, else external
  assign tx_int_eff = hw_mode_i ? impedance_sel_pin_i // [R5]
                    : !term_ff[T_TERM_LSB + TERM_EXT_BIT]; // [R4]
  assign tx_120_eff = hw_mode_i ? shape_eff[0] // [R5]
                    : term_ff[T_TERM_LSB + TERM_120_BIT]; // [R4]
  assign rx_int_eff = hw_mode_i ? impedance_sel_pin_i // [R5]
                    : !term_ff[R_TERM_LSB + TERM_EXT_BIT]; // [R12]
  assign rx_120_eff = hw_mode_i ? shape_eff[0] // [R5]
                    : term_ff[R_TERM_LSB + TERM_120_BIT]; // [R12]
  // strap gives only 0 or 26 dB; register code order 0/22/26/32 dB
  assign mon_eff = hw_mode_i ? (monitor_boost_pin_i ? MON_26DB : MON_0DB)
                 : rxc2_ff[MON_LSB +: 2]; // [R13] [R14] [R15]
  assign eq_eff = !hw_mode_i && rxc1_ff[EQ_BIT]; // [R17] [R18]
  assign pd_eff = hw_mode_i ? (pattern_pin_hi_i && pattern_pin_lo_i) // [R11]
                : txc0_ff[TX_OFF_BIT]; // [R10]
  assign tx_mode_eff = hw_mode_i
                     ? {path_mode_pin_hi_i, path_mode_pin_lo_i} // [R26]
                     : txc0_ff[TX_MODE_LSB +: 2];
  assign rx_mode_eff = hw_mode_i
                     ? {path_mode_pin_hi_i, path_mode_pin_lo_i} // [R26]
                     : rxc0_ff[RX_MODE_LSB +: 2];

  // settings registered so every output leaves a flip-flop
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_term_internal_o <= 1'b0;
      tx_term_120_o <= 1'b0;
      rx_term_internal_o <= 1'b0;
      rx_term_120_o <= 1'b0;
      monitor_boost_sel_o <= MON_0DB;
      los_enable_o <= 1'b0;
      equalizer_enable_o <= 1'b0;
      los_level_o <= LOS_LVL_FIXED;
      decision_threshold_sel_o <= 2'h0;
      tx_mode_o <= 2'h0;
      rx_rail_codec_mode_o <= 2'h0;
      rx_hdb3_o <= 1'b0;
      amplitude_scale_o <= RST_SCALE[5:0];
      tx_powerdown_o <= 1'b0;
    end else begin
      tx_term_internal_o <= tx_int_eff;
      tx_term_120_o <= tx_120_eff;
      rx_term_internal_o <= rx_int_eff;
      rx_term_120_o <= rx_120_eff;
      monitor_boost_sel_o <= mon_eff;
      los_enable_o <= (mon_eff == MON_0DB); // [R16]
      equalizer_enable_o <= eq_eff; // [R17] [R18]
      // level is programmable only with the equalizer running
      los_level_o <= eq_eff ? rxc1_ff[LOS_LVL_LSB +: 5]
                            : LOS_LVL_FIXED; // [R17] [R18]
      decision_threshold_sel_o <= rxc2_ff[THR_LSB +: 2]; // [R19]
      tx_mode_o <= tx_mode_eff;
      rx_rail_codec_mode_o <= rx_mode_eff; // [R24]
      rx_hdb3_o <= !rx_mode_eff[MODE_DUAL_BIT]
                && !rx_mode_eff[MODE_AMI_BIT]; // [R25]
      amplitude_scale_o <= txc2_ff[SCALE_LSB +: 6]; // [R3]
      tx_powerdown_o <= pd_eff; // [R10] [R11]
    end
  end

  // ===========================================================
  // transmit clock supervision
  logic txclk_d_ff;
  logic [CNT_W-1:0] idle_cnt_ff;
  logic txclk_edge;

  assign txclk_edge = tx_clock_i && !txclk_d_ff;

  // counts reference cycles since the last rising edge; saturates
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txclk_d_ff <= 1'b0;
      idle_cnt_ff <= '0;
    end else begin
      txclk_d_ff <= tx_clock_i;
      if (txclk_edge) begin
        idle_cnt_ff <= '0;
      end else if (idle_cnt_ff <= CNT_W'(LOSS_CYC)) begin
        idle_cnt_ff <= idle_cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_clock_lost_o <= 1'b0;
      tx_clk_irq_o <= 1'b0;
    end else begin
      tx_clock_lost_o <= idle_cnt_ff > CNT_W'(LOSS_CYC); // [R9]
      tx_clk_irq_o <= (idle_cnt_ff > CNT_W'(LOSS_CYC))
                   && !tx_clk_irq_mask_i; // [R9]
    end
  end

  // ===========================================================
  // transmit driver float
  logic after_reset_ff;

  // floated after any reset until software rewrites ADDR_TXC1,
  // or for one cycle in hardware mode where no write comes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      after_reset_ff <= 1'b1;
    end else if (sw_reset_i) begin
      after_reset_ff <= 1'b1; // [R8]
    end else if (hw_mode_i || is_wr(reg_req_i, ADDR_TXC1)) begin
      after_reset_ff <= 1'b0;
    end
  end

  assign float_req = (!hw_mode_i && txc1_ff[TX_FLOAT_BIT]) // [R6]
                  || (hw_mode_i && tx_float_pin_i) // [R7]
                  || mclk_lost_i || pd_eff || after_reset_ff // [R8]
                  || (tx_clock_lost_o && !remote_loopback_i
                      && !internal_pattern_i); // [R8]

  // pulse data keeps flowing while floated; only the enable drops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_line_pos_o <= 1'b0;
      tx_line_neg_o <= 1'b0;
      tx_line_oe_o <= 1'b0;
    end else begin
      tx_line_pos_o <= tx_pulse_pos_i; // [R6]
      tx_line_neg_o <= tx_pulse_neg_i;
      tx_line_oe_o <= !float_req; // [R6] [R7] [R8] [R10]
    end
  end

  // ===========================================================
  // waveform template store: preset rom or user ram
  logic [6:0] user_mem [64];

  // user ram has no reset; software must fill it before choosing it
  always_ff @(posedge ref_clk_i) begin
    if (tmpl_wr_i) begin
      user_mem[tmpl_waddr_i] <= template_sample_value_i; // [R27]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmpl_sample_o <= SAMPLE_ZERO;
    end else if (shape_eff[3:2] == SHAPE_USER) begin
      tmpl_sample_o <= user_mem[tmpl_raddr_i]; // [R28]
    end else begin
      tmpl_sample_o <= rom_sample(shape_eff[0], tmpl_raddr_i); // [R1] [R2]
    end
  end

  // ===========================================================
  // receive rail path with two-entry buffer
  e1fe_rail_s in_word;
  e1fe_rail_s buf_ff [2];
  logic [1:0] cnt_ff;
  logic rd_ptr_ff, wr_ptr_ff;
  logic push, pop, bypass;

  // bypass needs dual rail; mode 11 is the only dual-rail bypass code
  assign bypass = (rx_mode_eff == MODE_BYPASS); // [R22] [R23]
  assign in_word.pos = bypass ? rx_line_pos_i : cdr_pos_i; // [R20] [R21]
  assign in_word.neg = bypass ? rx_line_neg_i : cdr_neg_i; // [R20]
  assign in_word.clk = bypass ? (rx_line_pos_i ^ rx_line_neg_i) // [R23]
                              : cdr_clk_i;
  assign in_word.byp = bypass;
  assign push = rx_in_valid_i && rx_in_ready_o;
  assign pop = rx_out_valid_o && rx_out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      buf_ff[wr_ptr_ff] <= in_word; // [R20]
    end
  end

  // a receiver stall fills the buffer and then drops ready
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 2'h0;
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
    end else begin
      if (push) wr_ptr_ff <= !wr_ptr_ff;
      if (pop) rd_ptr_ff <= !rd_ptr_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // ready and valid registered from the next occupancy
  logic [1:0] nxt_cnt;
  assign nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_in_ready_o <= 1'b0;
      rx_out_valid_o <= 1'b0;
    end else begin
      rx_in_ready_o <= nxt_cnt != 2'h2;
      rx_out_valid_o <= nxt_cnt != 2'h0;
    end
  end

  // output word taken from the entry that will be at the head
  logic nxt_rd_ptr;
  e1fe_rail_s head;
  assign nxt_rd_ptr = pop ? !rd_ptr_ff : rd_ptr_ff;
  assign head = (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && pop))
              ? in_word : buf_ff[nxt_rd_ptr];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_rail_pos_o <= 1'b0;
      rx_rail_neg_o <= 1'b0;
      rx_clock_o <= 1'b0;
    end else begin
      rx_rail_pos_o <= head.pos;
      rx_rail_neg_o <= head.neg;
      rx_clock_o <= head.clk; // [R23]
    end
  end

  // ===========================================================
  // checks
  pd_float_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    pd_eff |=> !tx_line_oe_o && tx_powerdown_o) // [R10]
    else $error("power-down did not float transmit outputs");
  hw_pd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    hw_mode_i && pattern_pin_hi_i && pattern_pin_lo_i |=> tx_powerdown_o) // [R11]
    else $error("pattern pins did not power down transmit");
  float_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    hw_mode_i && tx_float_pin_i |=> !tx_line_oe_o) // [R7]
    else $error("float pin did not float transmit outputs");
  float_bit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !hw_mode_i && txc1_ff[TX_FLOAT_BIT] |=> !tx_line_oe_o
      && tx_line_pos_o == $past(tx_pulse_pos_i)) // [R6]
    else $error("float bit failed or stopped transmit data");
  clk_loss_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(tx_clock_lost_o) |-> $past(idle_cnt_ff) == CNT_W'(LOSS_CYC + 1)) // [R9]
    else $error("transmit clock loss flagged at wrong count");
  clk_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_clock_lost_o && !remote_loopback_i && !internal_pattern_i
      |=> !tx_line_oe_o) // [R8]
    else $error("lost transmit clock did not float outputs");
  rom_lead_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    shape_eff[3:2] != SHAPE_USER && tmpl_raddr_i == LEAD_IDX
      |=> tmpl_sample_o == ($past(shape_eff[0]) ? T120_LEAD : T75_LEAD)) // [R1]
    else $error("preset lead sample wrong");
  mon_los_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    monitor_boost_sel_o != MON_0DB |-> !los_enable_o) // [R16]
    else $error("loss-of-signal enabled in monitor mode");
  hw_eq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    hw_mode_i |=> !equalizer_enable_o && los_level_o == LOS_LVL_FIXED) // [R18]
    else $error("equalizer active in hardware mode");
  byp_clk_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_out_valid_o && head.byp |=> rx_clock_o == (rx_rail_pos_o
      ^ rx_rail_neg_o)) // [R23]
    else $error("bypass clock is not rail XOR");
  hdb3_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_mode_eff == 2'h0 |=> rx_hdb3_o) // [R25]
    else $error("single rail code 0 did not pick HDB3");
  full_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cnt_ff == 2'h2 |-> !rx_in_ready_o) // [R20]
    else $error("buffer accepted a word while full");
endmodule

// ---- logic/e1fe_pkg.sv ----
// e1fe_pkg: constants, field layout and carriers of the E1 line front-end
// control block; assumes an 8-bit register port and 7-bit template samples.
package e1fe_pkg;
  // ===========================================================
  // register offsets
  localparam logic [7:0] ADDR_TERM = 8'h03;
  localparam logic [7:0] ADDR_TXC0 = 8'h05;
  localparam logic [7:0] ADDR_TXC1 = 8'h06;
  localparam logic [7:0] ADDR_TXC2 = 8'h07;
  localparam logic [7:0] ADDR_RXC0 = 8'h0A;
  localparam logic [7:0] ADDR_RXC1 = 8'h0B;
  localparam logic [7:0] ADDR_RXC2 = 8'h0C;
  // ===========================================================
  // field positions
  localparam int T_TERM_LSB = 0;
  localparam int R_TERM_LSB = 3;
  localparam int TERM_EXT_BIT = 2;
  localparam int TERM_120_BIT = 0;
  localparam int TX_MODE_LSB = 0;
  localparam int TX_OFF_BIT = 4;
  localparam int SHAPE_LSB = 0;
  localparam int TX_FLOAT_BIT = 5;
  localparam int SCALE_LSB = 0;
  localparam int RX_MODE_LSB = 0;
  localparam int LOS_LVL_LSB = 0;
  localparam int EQ_BIT = 7;
  localparam int MON_LSB = 0;
  localparam int THR_LSB = 2;
  // ===========================================================
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SCALE = 8'h21;
  // ===========================================================
  // preset templates: lead sample then flat body, first unit interval
  localparam logic [6:0] T75_LEAD = 7'h0C;
  localparam logic [6:0] T75_BODY = 7'h30;
  localparam logic [6:0] T120_LEAD = 7'h0F;
  localparam logic [6:0] T120_BODY = 7'h3C;
  localparam logic [6:0] SAMPLE_ZERO = 7'h00;
  localparam logic [5:0] LEAD_IDX = 6'h03;
  localparam logic [5:0] BODY_FIRST = 6'h04;
  localparam logic [5:0] BODY_LAST = 6'h0B;
  localparam logic [1:0] SHAPE_USER = 2'h3;
  // ===========================================================
  // modes and codes
  localparam logic [1:0] MON_0DB = 2'h0;
  localparam logic [1:0] MON_26DB = 2'h2;
  localparam logic [1:0] MODE_BYPASS = 2'h3;
  localparam int MODE_DUAL_BIT = 1;
  localparam int MODE_AMI_BIT = 0;
  localparam logic [4:0] LOS_LVL_FIXED = 5'h00;
  localparam int TXCLK_LOSS_CYC = 70;
  // ===========================================================
  // carriers
  typedef struct packed {
    logic pos;
    logic neg;
    logic clk;
    logic byp;
  } e1fe_rail_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } e1fe_regreq_s;
endpackage

// ---- verification/e1fe_line_model.sv ----
// e1fe_line_model: far end of the line, a transmit clock source and
// changing receive rails; assumes it runs from the master clock.
`timescale 1ns/1ps
module e1fe_line_model (
  // clock, reset and control
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_run_i,
  // line side
  output logic tx_clock_o,
  output logic [2:0] rail_o
);
  logic [3:0] div_ff;
  // ==========================================================
  // line activity
  // clock stands low while stopped; rails change every cycle so a
  // stale sample can never pass for a fresh one
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= 4'h0;
      tx_clock_o <= 1'b0;
      rail_o <= 3'h5;
    end else begin
      div_ff <= #1 (div_ff == 4'h4) ? 4'h0 : div_ff + 4'h1;
      tx_clock_o <= #1 clk_run_i & (tx_clock_o ^ (div_ff == 4'h4));
      rail_o <= #1 rail_o + 3'h3;
    end
  end
endmodule

// ---- verification/tb.sv ----
// tb: self-checking bench for the line front-end control block.
// assumes e1fe_pkg, e1fe_ctrl and the line model are compiled first.
`timescale 1ns/1ps
module tb;
  import e1fe_pkg::*;
  // ==========================================================
  // signals
  logic ref_clk_i = 0, rst_n_i = 0, sw_reset_i = 0, hw_mode_i = 0;
  logic impedance_sel_pin_i = 0, tx_float_pin_i = 0, pattern_pin_hi_i = 0;
  logic pattern_pin_lo_i = 0, monitor_boost_pin_i = 0, mclk_lost_i = 0;
  logic path_mode_pin_hi_i = 0, path_mode_pin_lo_i = 0, clk_run = 1;
  logic remote_loopback_i = 0, internal_pattern_i = 0, tmpl_wr_i = 0;
  logic tx_clk_irq_mask_i = 0, tx_pulse_pos_i = 0, tx_pulse_neg_i = 0;
  logic rx_in_valid_i = 0, rx_out_ready_i = 0, tx_clock_i;
  logic [3:0] shape_template_sel_pin_i = 4'h0;
  logic [5:0] tmpl_waddr_i = 6'h00, tmpl_raddr_i = 6'h00;
  logic [6:0] template_sample_value_i = 7'h00, tmpl_sample_o;
  logic [2:0] rail;
  e1fe_regreq_s reg_req_i = '0;
  logic [7:0] reg_rdata_o;
  logic [5:0] amplitude_scale_o;
  logic [4:0] los_level_o;
  logic [1:0] monitor_boost_sel_o, decision_threshold_sel_o, tx_mode_o;
  logic [1:0] rx_rail_codec_mode_o, p;
  logic tx_line_pos_o, tx_line_neg_o, tx_line_oe_o, tx_powerdown_o;
  logic tx_clock_lost_o, tx_clk_irq_o, tx_term_internal_o, tx_term_120_o;
  logic rx_term_internal_o, rx_term_120_o, los_enable_o, equalizer_enable_o;
  logic rx_hdb3_o, rx_in_ready_o, rx_out_valid_o, rx_rail_pos_o;
  logic rx_rail_neg_o, rx_clock_o, rx_line_pos_i, rx_line_neg_i;
  logic cdr_pos_i, cdr_neg_i, cdr_clk_i;
  logic [3:0] term;
  int n_fail = 0, n_compared = 0;
  logic [1:0] q[$];
  assign {rx_line_neg_i, rx_line_pos_i} = rail[1:0];
  assign {cdr_clk_i, cdr_neg_i, cdr_pos_i} = ~rail;
  assign term = {tx_term_internal_o, tx_term_120_o, rx_term_internal_o,
    rx_term_120_o};
  e1fe_ctrl e1fe_ctrl_inst (.*);
  e1fe_line_model e1fe_line_model_inst (.ref_clk_i, .rst_n_i,
    .clk_run_i(clk_run), .tx_clock_o(tx_clock_i), .rail_o(rail));
  // 20 MHz master clock
  always #25 ref_clk_i = ~ref_clk_i;
  // ==========================================================
  // shared tasks; inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // settings outputs land one edge after the write is taken
  task automatic wr(input logic [7:0] a, d);
    step();
    reg_req_i = {1'b1, 1'b0, a, d};
    step();
    reg_req_i = '0;
    repeat (2) step();
  endtask
  task automatic rd(input logic [7:0] a, e);
    step();
    reg_req_i = {1'b0, 1'b1, a, 8'h00};
    step();
    reg_req_i = '0;
    chk(reg_rdata_o, e);
  endtask
  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  // reset values, unmapped read, preset and user templates
  task automatic t_tmpl();
    logic [5:0] ix[4] = '{LEAD_IDX, BODY_FIRST, BODY_LAST, 6'h0C};
    logic [6:0] e;
    chk({tx_line_oe_o, amplitude_scale_o}, {2'h0, RST_SCALE[5:0]});
    rd(ADDR_TXC2, RST_SCALE);
    rd(8'h01, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_TXC1, 8'(s));
      chk(tx_line_oe_o, 1'b1);
      for (int k = 0; k < 4; k++) begin
        e = s ? (k == 0 ? T120_LEAD : T120_BODY) : (k ? T75_BODY : T75_LEAD);
        tmpl_raddr_i = ix[k];
        step();
        chk(tmpl_sample_o, k == 3 ? SAMPLE_ZERO : e);
      end
    end
    wr(ADDR_TXC1, 8'h0C);
    {tmpl_wr_i, tmpl_waddr_i, template_sample_value_i} = {1'b1, 13'hA41};
    step();
    tmpl_wr_i = 0;
    tmpl_raddr_i = 6'h14;
    step();
    chk(tmpl_sample_o, 7'h41);
  endtask
  // termination, float, power-down, gain, threshold, equalizer
  task automatic t_cfg();
    wr(ADDR_TERM, 8'h08);
    chk(term, 4'hB);
    wr(ADDR_TERM, 8'h01);
    chk(term, 4'hE);
    wr(ADDR_TERM, 8'h3C);
    chk({term[3], term[1]}, 2'h0);
    tx_pulse_pos_i = 1;
    wr(ADDR_TXC1, 8'h20);
    chk({tx_line_oe_o, tx_line_pos_o}, 2'h1);
    wr(ADDR_TXC1, 8'h00);
    wr(ADDR_TXC0, 8'h10);
    chk({tx_line_oe_o, tx_powerdown_o}, 2'h1);
    wr(ADDR_TXC0, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_RXC2, 8'(c * 5));
      chk({monitor_boost_sel_o, decision_threshold_sel_o}, 8'(c * 5));
      chk(los_enable_o, c == 0);
    end
    wr(ADDR_RXC1, 8'h80);
    chk(equalizer_enable_o, 1'b1);
  endtask
  // transmit clock stops: loss flagged after the idle count, line floats
  task automatic t_loss();
    int i;
    wr(ADDR_TXC1, 8'h00);
    clk_run = 0;
    for (i = 0; i < 100 && tx_clock_lost_o !== 1'b1; i++) step();
    if (tx_clock_lost_o !== 1'b1) begin
      n_fail++;
      test_done();
    end
    chk({8'(i > 60), tx_clk_irq_o}, 2'h3);
    repeat (2) step();
    chk(tx_line_oe_o, 1'b0);
    clk_run = 1;
  endtask
  // decoder select, then bypass words through a stalled buffer
  task automatic t_rx();
    wr(ADDR_RXC0, 8'h01);
    chk(rx_hdb3_o, 1'b0);
    wr(ADDR_RXC0, {6'h00, MODE_BYPASS});
    rx_in_valid_i = 1;
    // capture at the edge itself, before the line model moves the rails
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk_i);
      if (rx_in_ready_o === 1'b1) q.push_back({rail[0], rail[1]});
      #1;
    end
    rx_in_valid_i = 0;
    chk(8'(q.size()), 8'h02);
    rx_out_ready_i = 1;
    for (int i = 0; i < 6; i++) begin
      if (rx_out_valid_o === 1'b1 && q.size() > 0) begin
        p = q.pop_front();
        chk({rx_rail_pos_o, rx_rail_neg_o, rx_clock_o}, {p, ^p});
      end
      step();
    end
    chk({rx_out_valid_o, 7'(q.size())}, 8'h00);
  endtask
  // strap control, then software reset floats the line again
  task automatic t_hw();
    {hw_mode_i, impedance_sel_pin_i, monitor_boost_pin_i} = 3'h7;
    {shape_template_sel_pin_i, path_mode_pin_hi_i, path_mode_pin_lo_i} = 6'h7;
    repeat (3) step();
    chk({term[3:2], monitor_boost_sel_o, equalizer_enable_o}, 5'h1C);
    chk({los_level_o, tx_mode_o, rx_rail_codec_mode_o}, 9'h00F);
    {tx_float_pin_i, impedance_sel_pin_i} = 2'h2;
    repeat (3) step();
    chk({tx_line_oe_o, term[3]}, 2'h0);
    {tx_float_pin_i, pattern_pin_hi_i, pattern_pin_lo_i} = 3'h3;
    repeat (3) step();
    chk({tx_powerdown_o, tx_line_oe_o}, 2'h2);
    hw_mode_i = 0;
    sw_reset_i = 1;
    step();
    sw_reset_i = 0;
    step();
    chk({tx_line_oe_o, amplitude_scale_o}, {2'h0, RST_SCALE[5:0]});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1;
    t_tmpl();
    t_cfg();
    t_loss();
    t_rx();
    t_hw();
    test_done();
  end
endmodule
